// ==== bench/test_scd_config.sv ====
// Self-checking testbench for the change detector configuration block.
`timescale 1ns/100ps

module test_scd_config
	import scd_pkg::*;
;

	// ==========================================================
	// Design connections
	logic                clk;
	logic                rstn;
	logic                boot_strap_pin;
	logic [7:0]          reg_addr;
	logic [7:0]          reg_wdata;
	logic                reg_wr;
	logic                reg_rd;
	logic [7:0]          reg_rdata;
	logic                sample_valid;
	logic [SAMPLE_W-1:0] sample_x;
	logic [SAMPLE_W-1:0] sample_y;
	logic [SAMPLE_W-1:0] sample_z;
	logic                outside_event_flag;
	logic                det_clock_en;
	logic                det_power_en;
	logic                eval_strobe;
	logic [2:0]          outside_axis_mask;
	logic [2:0]          inside_axis_mask;
	logic [1:0]          reference_update_mode;
	logic                outside_debounce_mode;
	logic                inside_debounce_mode;
	logic                inside_logic_select;
	logic                input_mode;
	logic [SAMPLE_W-1:0] ref_x;
	logic [SAMPLE_W-1:0] ref_y;
	logic [SAMPLE_W-1:0] ref_z;

	// ==========================================================
	// Bench state
	int                  n_errors;
	int                  samples_checked;
	int                  cycles;
	logic                rd_d;
	logic [7:0]          exp_q[$];
	logic [SAMPLE_W-1:0] cur[3];
	logic [SAMPLE_W-1:0] held[3];
	logic [7:0]          v;

	scd_config u_dut (
		.clk                   (clk),
		.rstn                  (rstn),
		.boot_strap_pin        (boot_strap_pin),
		.reg_addr              (reg_addr),
		.reg_wdata             (reg_wdata),
		.reg_wr                (reg_wr),
		.reg_rd                (reg_rd),
		.reg_rdata             (reg_rdata),
		.sample_valid          (sample_valid),
		.sample_x              (sample_x),
		.sample_y              (sample_y),
		.sample_z              (sample_z),
		.outside_event_flag    (outside_event_flag),
		.det_clock_en          (det_clock_en),
		.det_power_en          (det_power_en),
		.eval_strobe           (eval_strobe),
		.outside_axis_mask     (outside_axis_mask),
		.inside_axis_mask      (inside_axis_mask),
		.reference_update_mode (reference_update_mode),
		.outside_debounce_mode (outside_debounce_mode),
		.inside_debounce_mode  (inside_debounce_mode),
		.inside_logic_select   (inside_logic_select),
		.input_mode            (input_mode),
		.ref_x                 (ref_x),
		.ref_y                 (ref_y),
		.ref_z                 (ref_z)
	);

	// ==========================================================
	// Clock, timeout and read monitor
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic results();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge clk) begin
		rd_d <= reg_rd;
		cycles++;
		if (cycles == 4000) begin
			n_errors++;
			results();
		end
	end

	// Read data is valid in the cycle after the strobe; compare oldest note.
	always @(negedge clk) begin
		if (rd_d === 1'b1) begin
			if (exp_q.size() == 0)
				chk(16'hFFFF, 16'h0000);
			else
				chk(reg_rdata, exp_q.pop_front());
		end
	end

	// ==========================================================
	// Drivers
	task automatic rst(input logic strap);
		@(posedge clk);
		#10;
		boot_strap_pin = strap;
		rstn = 1'b0;
		repeat (12) @(posedge clk);
		#10;
		rstn = 1'b1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#10;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#10;
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		#10;
		reg_addr = a;
		reg_rd = 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		#10;
		reg_rd = 1'b0;
	endtask

	// Sends one random sample and checks the evaluation strobe with it.
	task automatic smp(input logic ev);
		@(posedge clk);
		#10;
		foreach (cur[i]) cur[i] = SAMPLE_W'($urandom);
		sample_x = cur[0];
		sample_y = cur[1];
		sample_z = cur[2];
		sample_valid = 1'b1;
		#1;
		chk(eval_strobe, ev);
		@(posedge clk);
		#10;
		sample_valid = 1'b0;
	endtask

	task automatic cref(input logic [SAMPLE_W-1:0] r[3]);
		chk(ref_x, r[0]);
		chk(ref_y, r[1]);
		chk(ref_z, r[2]);
	endtask

	// ==========================================================
	// Test sequence
	initial begin
		n_errors = 0;
		samples_checked = 0;
		cycles = 0;
		rstn = 1'b0;
		boot_strap_pin = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		sample_valid = 1'b0;
		sample_x = 12'h000;
		sample_y = 12'h000;
		sample_z = 12'h000;
		outside_event_flag = 1'b0;
		void'($urandom(95286));

		rst(1'b0);
		rd(ADDR_CTRL, 8'h00);
		rd(ADDR_AXIS_CFG, 8'h00);
		rd(8'h31, 8'h00);
		chk(det_clock_en, 1'b0);
		rst(1'b1);
		rd(ADDR_CTRL, 8'hD8);
		chk({det_clock_en, det_power_en}, 2'h3);
		chk(reference_update_mode, 2'h2);
		chk({outside_debounce_mode, inside_debounce_mode}, 2'h3);
		$display("test strap reset done");

		for (int i = 0; i < 9; i++) begin
			v = (i < 6) ? (8'h01 << i) : 8'($urandom) & 8'h3F;
			wr(ADDR_AXIS_CFG, v);
			chk(outside_axis_mask, v[5:3]);
			chk(inside_axis_mask, v[2:0]);
			rd(ADDR_AXIS_CFG, v);
		end
		$display("test axis enables done");

		wr(ADDR_CTRL, 8'h1E);
		chk({det_clock_en, det_power_en}, 2'h0);
		chk({outside_debounce_mode, inside_debounce_mode}, 2'h3);
		chk({inside_logic_select, input_mode}, 2'h3);
		chk(reference_update_mode, 2'h0);
		rd(ADDR_CTRL, 8'h1E);
		wr(ADDR_CTRL, 8'h00);
		$display("test control fields done");

		wr(ADDR_CTRL, 8'h80);
		smp(1'b0);
		held = cur;
		cref(held);
		smp(1'b1);
		cref(held);
		outside_event_flag = 1'b1;
		@(posedge clk);
		#10;
		cref(cur);
		outside_event_flag = 1'b0;
		wr(ADDR_CTRL, 8'h00);
		$display("test on event mode done");

		wr(ADDR_CTRL, 8'hA0);
		smp(1'b0);
		held = cur;
		smp(1'b1);
		cref(held);
		wr(ADDR_CTRL, 8'hA1);
		smp(1'b1);
		cref(cur);
		held = cur;
		rd(ADDR_CTRL, 8'hA0);
		wr(ADDR_CTRL, 8'h20);
		smp(1'b0);
		cref(held);
		wr(ADDR_CTRL, 8'hA0);
		smp(1'b0);
		cref(cur);
		wr(ADDR_CTRL, 8'h00);
		$display("test hold mode done");

		wr(ADDR_CTRL, 8'hC0);
		smp(1'b0);
		for (int i = 0; i < 3; i++) begin
			smp(1'b1);
			cref(cur);
		end
		wr(ADDR_CTRL, 8'h00);
		$display("test slope mode done");

		wr(ADDR_CTRL, 8'hE0);
		repeat (2) @(posedge clk);
		#10;
		held = '{12'h000, 12'h000, 12'h000};
		cref(held);
		wr(ADDR_CTRL, 8'hE1);
		smp(1'b1);
		cref(held);
		rd(ADDR_CTRL, 8'hE0);
		$display("test absolute mode done");

		repeat (3) @(posedge clk);
		results();
	end

endmodule

// ==== hdl/scd_axis_ref.sv ====
// One axis reference value register with load and clear.
`timescale 1ns/100ps

module scd_axis_ref
	import scd_pkg::*;
#(
	parameter int W = SAMPLE_W
)(
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         load,
	input  wire logic         clear,
	input  wire logic [W-1:0] value,
	output logic      [W-1:0] ref_val
);

	// ==========================================================
	// Reference register
	logic [W-1:0] ref_r;
	logic [W-1:0] ref_nxt;

	always_comb begin
		ref_nxt = ref_r;
		if (clear) begin
			ref_nxt = '0;
		end else if (load) begin
			ref_nxt = value;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ref_r <= '0;
		end else begin
			ref_r <= ref_nxt;
		end
	end

	assign ref_val = ref_r;

endmodule

// ==== hdl/scd_config.sv ====
// Sample change detector configuration registers and reference handling.
//
// Notes on behaviour
// - Axis config bits 4 and 3 include Y and Z in the outside-window test.
// - Axis config bits 2, 1 and 0 include X, Y, Z in the inside-window test.
// - Control bit 7 low disables the detector with clocks and power off.
// - Control resets to zero on a low strap, to 8'hD8 on a high strap.
// - Setting enable initialises the three 12-bit references per the mode.
// - Mode 00b loads the first sample, then reloads on each event flag rise.
// - Mode 01b holds the first sample until re-enable or an update request.
// - Mode 10b overwrites the references with each sample after evaluation.
// - Mode 11b keeps all three references at zero.
// - Control: mode 6:5, debounces 4 and 3, logic 2, input 1, request 0.
// - Axis config bit 5 includes X in the outside-window test.
// - The request bit clears itself after the reload, within one sample.
`timescale 1ns/100ps

module scd_config
	import scd_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                rstn,
	input  wire logic                boot_strap_pin,
	input  wire logic [7:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [7:0]          reg_rdata,
	input  wire logic                sample_valid,
	input  wire logic [SAMPLE_W-1:0] sample_x,
	input  wire logic [SAMPLE_W-1:0] sample_y,
	input  wire logic [SAMPLE_W-1:0] sample_z,
	input  wire logic                outside_event_flag,
	output logic                     det_clock_en,
	output logic                     det_power_en,
	output logic                     eval_strobe,
	output logic      [2:0]          outside_axis_mask,
	output logic      [2:0]          inside_axis_mask,
	output logic      [1:0]          reference_update_mode,
	output logic                     outside_debounce_mode,
	output logic                     inside_debounce_mode,
	output logic                     inside_logic_select,
	output logic                     input_mode,
	output logic      [SAMPLE_W-1:0] ref_x,
	output logic      [SAMPLE_W-1:0] ref_y,
	output logic      [SAMPLE_W-1:0] ref_z
);

	// ==========================================================
	// Strap synchroniser
	logic strap_s1_r;
	logic strap_s2_r;

	// The strap is static; it is sampled only through the second stage.
	always_ff @(posedge clk) begin
		strap_s1_r <= boot_strap_pin;
		strap_s2_r <= strap_s1_r;
	end

	// ==========================================================
	// Registers
	logic [7:0] axis_cfg_r;
	logic [7:0] axis_cfg_nxt;
	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic       upd_done;
	logic       wr_axis;
	logic       wr_ctrl;

	assign wr_axis = reg_wr && (reg_addr == ADDR_AXIS_CFG);
	assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);

	always_comb begin
		axis_cfg_nxt = axis_cfg_r;
		ctrl_nxt     = ctrl_r;
		rdata_nxt    = rdata_r;
		if (wr_axis) begin
			axis_cfg_nxt = reg_wdata;
		end
		if (wr_ctrl) begin
			ctrl_nxt = reg_wdata;
		end
		// A request written in the completing cycle survives.
		if (upd_done && !(wr_ctrl && reg_wdata[CTRL_UPD_REQ])) begin
			ctrl_nxt[CTRL_UPD_REQ] = 1'b0;
		end
		if (reg_rd) begin
			if (reg_addr == ADDR_AXIS_CFG) begin
				rdata_nxt = axis_cfg_r;
			end else if (reg_addr == ADDR_CTRL) begin
				rdata_nxt = ctrl_r;
			end else begin
				rdata_nxt = RDATA_UNMAPPED;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			axis_cfg_r <= AXIS_CFG_RST;
			ctrl_r     <= strap_s2_r ? CTRL_RST_STRAP_HIGH
			                         : CTRL_RST_STRAP_LOW;
			rdata_r    <= RDATA_UNMAPPED;
		end else begin
			axis_cfg_r <= axis_cfg_nxt;
			ctrl_r     <= ctrl_nxt;
			rdata_r    <= rdata_nxt;
		end
	end

	// ==========================================================
	// Field outputs
	logic       en;
	logic [1:0] mode;
	logic       req;

	assign en   = ctrl_r[CTRL_EN];
	assign mode = ctrl_r[CTRL_MODE_HI:CTRL_MODE_LO];
	assign req  = ctrl_r[CTRL_UPD_REQ];

	assign reg_rdata             = rdata_r;
	assign det_clock_en          = en;
	assign det_power_en          = en;
	assign outside_axis_mask     = axis_cfg_r[AXIS_X_OUT:AXIS_Z_OUT];
	assign inside_axis_mask      = axis_cfg_r[AXIS_X_IN:AXIS_Z_IN];
	assign reference_update_mode = mode;
	assign outside_debounce_mode = ctrl_r[CTRL_OUT_DBM];
	assign inside_debounce_mode  = ctrl_r[CTRL_IN_DBM];
	assign inside_logic_select   = ctrl_r[CTRL_IN_LOG];
	assign input_mode            = ctrl_r[CTRL_INMODE];

	// ==========================================================
	// Reference tracking
	scd_ref_state_t state_r;
	scd_ref_state_t state_nxt;
	logic [SAMPLE_W-1:0] last_r   [AXES];
	logic [SAMPLE_W-1:0] last_nxt [AXES];
	logic [SAMPLE_W-1:0] samp     [AXES];
	logic [SAMPLE_W-1:0] refv     [AXES];
	logic                flag_prev_r;
	logic                flag_rise;
	logic                ref_load;
	logic                ref_clear;
	logic                use_last;

	assign samp[0]   = sample_x;
	assign samp[1]   = sample_y;
	assign samp[2]   = sample_z;
	assign flag_rise = outside_event_flag && !flag_prev_r;
	// Evaluation runs only once references are valid.
	assign eval_strobe = sample_valid && en
	                     && (state_r == SCD_REF_RUN);

	always_comb begin
		state_nxt = state_r;
		ref_load  = 1'b0;
		ref_clear = 1'b0;
		use_last  = 1'b0;
		upd_done  = 1'b0;
		for (int i = 0; i < AXES; i++) begin
			last_nxt[i] = sample_valid ? samp[i] : last_r[i];
		end
		case (state_r)
			SCD_REF_OFF: begin
				if (en) begin
					state_nxt = SCD_REF_FIRST;
				end
			end
			SCD_REF_FIRST: begin
				if (!en) begin
					state_nxt = SCD_REF_OFF;
				end else if (mode == UPDM_ABSOLUTE) begin
					ref_clear = 1'b1;
					state_nxt = SCD_REF_RUN;
				end else if (sample_valid) begin
					ref_load  = 1'b1;
					upd_done  = req;
					state_nxt = SCD_REF_RUN;
				end
			end
			SCD_REF_RUN: begin
				if (!en) begin
					state_nxt = SCD_REF_OFF;
				end else if (mode == UPDM_ABSOLUTE) begin
					ref_clear = 1'b1;
					upd_done  = sample_valid && req;
				end else if (sample_valid
				             && (req || mode == UPDM_SLOPE)) begin
					ref_load = 1'b1;
					upd_done = req;
				end else if (mode == UPDM_ON_EVENT && flag_rise) begin
					ref_load = 1'b1;
					use_last = 1'b1;
				end
			end
			default: begin
				state_nxt = SCD_REF_OFF;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_r     <= SCD_REF_OFF;
			flag_prev_r <= 1'b0;
			for (int i = 0; i < AXES; i++) begin
				last_r[i] <= '0;
			end
		end else begin
			state_r     <= state_nxt;
			flag_prev_r <= outside_event_flag;
			for (int i = 0; i < AXES; i++) begin
				last_r[i] <= last_nxt[i];
			end
		end
	end

	for (genvar g = 0; g < AXES; g++) begin : g_axis
		scd_axis_ref #(
			.W (SAMPLE_W)
		) u_ref (
			.clk     (clk),
			.rstn    (rstn),
			.load    (ref_load),
			.clear   (ref_clear),
			.value   (use_last ? last_r[g] : samp[g]),
			.ref_val (refv[g])
		);
	end

	assign ref_x = refv[0];
	assign ref_y = refv[1];
	assign ref_z = refv[2];

	// ==========================================================
	// Assertions
	sequence s_abs_held;
		(en && mode == UPDM_ABSOLUTE)[*3];
	endsequence

	sequence s_axis_write;
		wr_axis ##1 1'b1;
	endsequence

	property p_out_mask;
		@(posedge clk) disable iff (!rstn)
		wr_axis |=> (outside_axis_mask == $past(reg_wdata[5:3]));
	endproperty
	a_out_mask: assert property (p_out_mask)
		else $error("outside mask does not follow axis write");

	property p_in_mask;
		@(posedge clk) disable iff (!rstn)
		s_axis_write |-> (inside_axis_mask == $past(reg_wdata[2:0]));
	endproperty
	a_in_mask: assert property (p_in_mask)
		else $error("inside mask does not follow axis write");

	property p_disable;
		@(posedge clk) disable iff (!rstn)
		(wr_ctrl && !reg_wdata[CTRL_EN]) |=>
			(!det_clock_en && !det_power_en && !eval_strobe)
			##1 (state_r == SCD_REF_OFF);
	endproperty
	a_disable: assert property (p_disable)
		else $error("detector not shut down after disable");

	property p_strap;
		@(posedge clk)
		(!rstn && strap_s2_r) |=> (ctrl_r == CTRL_RST_STRAP_HIGH);
	endproperty
	a_strap: assert property (p_strap)
		else $error("control reset value wrong for high strap");

	property p_enable_init;
		@(posedge clk) disable iff (!rstn)
		($rose(en) && state_r == SCD_REF_OFF) |=>
			(state_r == SCD_REF_FIRST);
	endproperty
	a_enable_init: assert property (p_enable_init)
		else $error("enable did not start reference capture");

	property p_event_reload;
		@(posedge clk) disable iff (!rstn)
		(state_r == SCD_REF_RUN && en && mode == UPDM_ON_EVENT
		 && flag_rise && !sample_valid && !req) |=>
			(ref_x == $past(last_r[0]) && ref_z == $past(last_r[2]));
	endproperty
	a_event_reload: assert property (p_event_reload)
		else $error("reference not reloaded on event rise");

	property p_hold;
		@(posedge clk) disable iff (!rstn)
		(state_r == SCD_REF_RUN && en && mode == UPDM_HOLD && !req)
			|=> $stable(ref_y);
	endproperty
	a_hold: assert property (p_hold)
		else $error("held reference changed");

	property p_slope;
		@(posedge clk) disable iff (!rstn)
		(state_r == SCD_REF_RUN && en && mode == UPDM_SLOPE
		 && sample_valid) |=> (ref_x == $past(sample_x));
	endproperty
	a_slope: assert property (p_slope)
		else $error("slope reference not updated");

	property p_absolute;
		@(posedge clk) disable iff (!rstn)
		s_abs_held |-> (ref_x == '0 && ref_y == '0 && ref_z == '0);
	endproperty
	a_absolute: assert property (p_absolute)
		else $error("absolute mode reference not zero");

	property p_ctrl_fields;
		@(posedge clk) disable iff (!rstn)
		wr_ctrl |=> (reference_update_mode == $past(reg_wdata[6:5])
		             && inside_logic_select == $past(reg_wdata[2]));
	endproperty
	a_ctrl_fields: assert property (p_ctrl_fields)
		else $error("control fields do not follow write");

	property p_req_clear;
		@(posedge clk) disable iff (!rstn)
		(req && en && state_r == SCD_REF_RUN && sample_valid
		 && !wr_ctrl) |=> !req;
	endproperty
	a_req_clear: assert property (p_req_clear)
		else $error("update request did not self clear");

	property p_ref_paced;
		@(posedge clk) disable iff (!rstn)
		!(sample_valid || flag_rise || ref_clear) |=> $stable(ref_x);
	endproperty
	a_ref_paced: assert property (p_ref_paced)
		else $error("reference changed without a sample or event");

endmodule

// ==== shared/scd_pkg.sv ====
// Constants for the sample change detector configuration and references.
package scd_pkg;

	// ==========================================================
	// Register addresses
	localparam logic [7:0] ADDR_AXIS_CFG = 8'h2F;
	localparam logic [7:0] ADDR_CTRL     = 8'h30;

	// ==========================================================
	// Axis configuration register fields
	localparam int AXIS_X_OUT = 5;
	localparam int AXIS_Y_OUT = 4;
	localparam int AXIS_Z_OUT = 3;
	localparam int AXIS_X_IN  = 2;
	localparam int AXIS_Y_IN  = 1;
	localparam int AXIS_Z_IN  = 0;
	localparam logic [7:0] AXIS_CFG_RST = 8'h00;

	// ==========================================================
	// Control register fields
	localparam int CTRL_EN      = 7;
	localparam int CTRL_MODE_HI = 6;
	localparam int CTRL_MODE_LO = 5;
	localparam int CTRL_OUT_DBM = 4;
	localparam int CTRL_IN_DBM  = 3;
	localparam int CTRL_IN_LOG  = 2;
	localparam int CTRL_INMODE  = 1;
	localparam int CTRL_UPD_REQ = 0;
	localparam logic [7:0] CTRL_RST_STRAP_LOW  = 8'h00;
	localparam logic [7:0] CTRL_RST_STRAP_HIGH = 8'hD8;

	// ==========================================================
	// Reference update modes
	localparam logic [1:0] UPDM_ON_EVENT = 2'h0;
	localparam logic [1:0] UPDM_HOLD     = 2'h1;
	localparam logic [1:0] UPDM_SLOPE    = 2'h2;
	localparam logic [1:0] UPDM_ABSOLUTE = 2'h3;

	// ==========================================================
	// Widths and reference tracking states
	localparam int SAMPLE_W = 12;
	localparam int AXES     = 3;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

	typedef enum logic [1:0] {
		SCD_REF_OFF,
		SCD_REF_FIRST,
		SCD_REF_RUN
	} scd_ref_state_t;

endpackage
